/* File: hdl/vrhp_map.svh */
// Register layout, command codes and timing constants of the host port.
`ifndef VRHP_MAP_SVH
`define VRHP_MAP_SVH
`define VRHP_CLK_MHZ        25
`define VRHP_T_RESET_US     1000
`define VRHP_T_CMD_US       16
`define VRHP_T_READ_US      270
`define VRHP_T_DOUT_US      50
`define VRHP_T_INDEX_USER_DATA_ACCESS_US      770
`define VRHP_T_DELALL_MS    550
`define VRHP_T_PHRASE_DELETE_MS      70
`define VRHP_CYC_RESET      (`VRHP_T_RESET_US * `VRHP_CLK_MHZ)
`define VRHP_CYC_CMD        (`VRHP_T_CMD_US * `VRHP_CLK_MHZ)
`define VRHP_CYC_READ       (`VRHP_T_READ_US * `VRHP_CLK_MHZ)
`define VRHP_CYC_DOUT       (`VRHP_T_DOUT_US * `VRHP_CLK_MHZ)
`define VRHP_CYC_INDEX_USER_DATA_ACCESS       (`VRHP_T_INDEX_USER_DATA_ACCESS_US * `VRHP_CLK_MHZ)
`define VRHP_CYC_DELALL     (`VRHP_T_DELALL_MS * 1000 * `VRHP_CLK_MHZ)
`define VRHP_CYC_PHRASE_DELETE       (`VRHP_T_PHRASE_DELETE_MS * 1000 * `VRHP_CLK_MHZ)
`define VRHP_BIT_BUSY       0
`define VRHP_BIT_ACTIVE     1
`define VRHP_BIT_WAIT       2
`define VRHP_BIT_READY      3
`define VRHP_FLAGS_RESET    4'h8
`define VRHP_CMD_NOP        4'h0
`define VRHP_CMD_PAUSE      4'h1
`define VRHP_CMD_PLAY       4'h2
`define VRHP_CMD_REC        4'h3
`define VRHP_CMD_START      4'h4
`define VRHP_CMD_STOP       4'h5
`define VRHP_CMD_BRATE      4'h6
`define VRHP_CMD_PHRASE_SELECT       4'h7
`define VRHP_CMD_BLK        4'h8
`define VRHP_CMD_BLOCK_COUNT_READ      4'h9
`define VRHP_CMD_XFER       4'hA
`define VRHP_CMD_FLAGSEL    4'hC
`define VRHP_CMD_DEL        4'hD
`define VRHP_CMD_LEV        4'hE
`define VRHP_LEVEL_RESET    2'h0
`define VRHP_RAMP_OFF       2'h0
`define VRHP_RAMP_UP        2'h2
`define VRHP_RAMP_DOWN      2'h3
`endif

/* File: hdl/vrhp_pkg.sv */
// Types shared by the host port modules.
package vrhp_pkg;
  typedef struct packed {
    logic ready;
    logic wait_pause;
    logic active;
    logic busy;
  } vrhp_flags_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic en;
  } vrhp_strobe_type;

  typedef enum logic [3:0] {
    VRHP_IDLE = 4'b0001,
    VRHP_DATA = 4'b0010,
    VRHP_RUN  = 4'b0100,
    VRHP_VWAIT = 4'b1000
  } vrhp_state_type;
endpackage

/* File: hdl/vrhp_sync.sv */
// Two-stage synchroniser and edge detector for the host strobes.
`timescale 1ns/100ps
`default_nettype none
module vrhp_sync (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Raw pins
  input  wire logic                      rd_n,
  input  wire logic                      wr_n,
  input  wire logic                      en_n,
  input  wire logic                      en,
  // Synchronised view
  output var  vrhp_pkg::vrhp_strobe_type level,
  output var  logic                      wr_take,
  output var  logic                      rd_take
);
  logic [2:0] meta;
  logic [2:0] next_meta;
  vrhp_pkg::vrhp_strobe_type next_level;
  vrhp_pkg::vrhp_strobe_type prev_level;
  vrhp_pkg::vrhp_strobe_type next_prev;
  logic next_wr_take;
  logic next_rd_take;

  always_comb begin
    next_meta = {~rd_n, ~wr_n, ~en_n & en};
    next_level = vrhp_pkg::vrhp_strobe_type'(meta);
    next_prev = level;
    // Only the second stage feeds the edge detector; the first may still be settling.
    // A strobe counts once, on its falling edge, and only while enabled.
    next_wr_take = level.wr & ~prev_level.wr & level.en;
    next_rd_take = level.rd & ~prev_level.rd & level.en;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta       <= 3'h0;
      level      <= '0;
      prev_level <= '0;
      wr_take    <= 1'b0;
      rd_take    <= 1'b0;
    end else begin
      meta       <= next_meta;
      level      <= next_level;
      prev_level <= next_prev;
      wr_take    <= next_wr_take;
      rd_take    <= next_rd_take;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/vrhp_host_port.sv */
// Host command and status port of the voice recorder controller.
`timescale 1ns/100ps
`default_nettype none
`include "vrhp_map.svh"
module vrhp_host_port #(
  parameter int unsigned RESET_CYCLES  = `VRHP_CYC_RESET,
  parameter int unsigned DELALL_CYCLES = `VRHP_CYC_DELALL,
  parameter int unsigned PHRASE_DELETE_CYCLES   = `VRHP_CYC_PHRASE_DELETE
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Host bus
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       en_n,
  input  wire logic       en,
  input  wire logic [3:0] data_in,
  output var  logic [3:0] data_out,
  output var  logic [3:0] data_oe_n,
  // Status pins
  output var  logic       busy,
  output var  logic       record_play_active,
  output var  logic       voice_wait_or_paused,
  output var  logic       phrase_select_ready,
  // Datapath side
  input  wire logic       voice_detected,
  input  wire logic       op_done,
  output var  logic [1:0] level_field,
  output var  logic [1:0] ramp_select,
  output var  logic       delete_all,
  output var  logic       delete_one
);
  localparam int unsigned MAX_A   = (DELALL_CYCLES > RESET_CYCLES) ? DELALL_CYCLES : RESET_CYCLES;
  localparam int unsigned MAX_CYC = (MAX_A > `VRHP_CYC_INDEX_USER_DATA_ACCESS) ? MAX_A : `VRHP_CYC_INDEX_USER_DATA_ACCESS;
  localparam int unsigned CNT_W   = $clog2(MAX_CYC + 1);

  if (RESET_CYCLES < 1 || PHRASE_DELETE_CYCLES < 1 || DELALL_CYCLES < PHRASE_DELETE_CYCLES) begin : g_bad_counts
    $error("vrhp_host_port: busy counts out of range");
  end

  vrhp_pkg::vrhp_strobe_type lvl;
  logic                      wr_take;
  logic                      rd_take;

  vrhp_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rd_n     (rd_n),
    .wr_n     (wr_n),
    .en_n     (en_n),
    .en       (en),
    .level    (lvl),
    .wr_take  (wr_take),
    .rd_take  (rd_take)
  );

  vrhp_pkg::vrhp_state_type state;
  vrhp_pkg::vrhp_state_type next_state;
  vrhp_pkg::vrhp_flags_type operation_flags;
  vrhp_pkg::vrhp_flags_type next_flags;
  logic [CNT_W-1:0] busy_cnt;
  logic [CNT_W-1:0] next_busy_cnt;
  logic [3:0]       cmd;
  logic [3:0]       next_cmd;
  logic [2:0]       nib_left;
  logic [2:0]       next_nib_left;
  logic [2:0]       nib_idx;
  logic [2:0]       next_nib_idx;
  logic [7:0]       phrase;
  logic [7:0]       next_phrase;
  logic             vox_on;
  logic             next_vox_on;
  logic [1:0]       next_level;
  logic [1:0]       next_ramp;
  logic             next_del_all;
  logic             next_del_one;
  logic [3:0]       next_dout;
  logic [3:0]       next_oe_n;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction

  always_comb begin
    next_state    = state;
    next_flags    = operation_flags;
    next_busy_cnt = busy_cnt;
    next_cmd      = cmd;
    next_nib_left = nib_left;
    next_nib_idx  = nib_idx;
    next_phrase   = phrase;
    next_vox_on   = vox_on;
    next_level    = level_field;
    next_ramp     = ramp_select;
    next_del_all  = 1'b0;
    next_del_one  = 1'b0;
    // Busy falls when its count runs out.
    if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - cyc(1);
    end
    // Datapath events go first, so that a write in the same cycle overrides them.
    case (state)
      vrhp_pkg::VRHP_VWAIT: begin
        if (voice_detected) begin
          next_flags.wait_pause = 1'b0;
          next_state = vrhp_pkg::VRHP_RUN;
        end
      end
      vrhp_pkg::VRHP_RUN: begin
        if (op_done) begin
          next_flags.active     = 1'b0;
          next_flags.wait_pause = 1'b0;
          next_flags.ready      = 1'b1;
          next_state = vrhp_pkg::VRHP_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (wr_take) begin
      next_busy_cnt = cyc(`VRHP_CYC_CMD);
      if (state == vrhp_pkg::VRHP_DATA) begin
        next_nib_left = nib_left - 3'h1;
        next_nib_idx  = nib_idx + 3'h1;
        case (cmd)
          `VRHP_CMD_PHRASE_SELECT: begin
            if (nib_idx == 3'h0) next_phrase[3:0] = data_in;
            else next_phrase[7:4] = data_in;
          end
          `VRHP_CMD_LEV: begin
            next_level = data_in[3:2];
            next_ramp  = data_in[1] ? data_in[1:0] : `VRHP_RAMP_OFF;
          end
          `VRHP_CMD_FLAGSEL: begin
            next_vox_on = (data_in != 4'h0);
          end
          `VRHP_CMD_BLOCK_COUNT_READ: begin
            next_busy_cnt = cyc(`VRHP_CYC_DOUT);
          end
          `VRHP_CMD_XFER: begin
            if (nib_left == 3'h1) next_busy_cnt = cyc(`VRHP_CYC_READ);
          end
          default: begin
          end
        endcase
        if (nib_left == 3'h1) next_state = vrhp_pkg::VRHP_IDLE;
      end else begin
        next_cmd      = data_in;
        next_nib_idx  = 3'h0;
        next_nib_left = 3'h0;
        case (data_in)
          `VRHP_CMD_BRATE, `VRHP_CMD_LEV, `VRHP_CMD_FLAGSEL: next_nib_left = 3'h1;
          `VRHP_CMD_PHRASE_SELECT, `VRHP_CMD_BLK: next_nib_left = 3'h2;
          `VRHP_CMD_BLOCK_COUNT_READ: begin
            next_nib_left = 3'h2;
            next_busy_cnt = cyc(`VRHP_CYC_READ);
          end
          `VRHP_CMD_XFER: begin
            next_nib_left = 3'h5;
            next_busy_cnt = cyc(`VRHP_CYC_INDEX_USER_DATA_ACCESS);
          end
          `VRHP_CMD_DEL: begin
            if (phrase == 8'h00) begin
              next_busy_cnt = cyc(DELALL_CYCLES);
              next_del_all  = 1'b1;
            end else begin
              next_busy_cnt = cyc(PHRASE_DELETE_CYCLES);
              next_del_one  = 1'b1;
            end
          end
          `VRHP_CMD_START: begin
            next_flags.wait_pause = vox_on & ~voice_detected;
            next_flags.active     = 1'b1;
            next_flags.ready      = 1'b0;
            next_state = vox_on & ~voice_detected ? vrhp_pkg::VRHP_VWAIT
                                                  : vrhp_pkg::VRHP_RUN;
          end
          `VRHP_CMD_PAUSE: begin
            if (next_flags.active) next_flags.wait_pause = 1'b1;
          end
          `VRHP_CMD_STOP: begin
            next_flags.active     = 1'b0;
            next_flags.wait_pause = 1'b0;
            next_flags.ready      = 1'b1;
            next_state            = vrhp_pkg::VRHP_IDLE;
          end
          default: begin
          end
        endcase
        if (next_nib_left != 3'h0) next_state = vrhp_pkg::VRHP_DATA;
      end
    end
    next_flags.busy = (next_busy_cnt != '0);
    // Status drives the bus only during an enabled read.
    next_oe_n = (lvl.rd & lvl.en) ? 4'h0 : 4'hF;
    next_dout = operation_flags;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state           <= vrhp_pkg::VRHP_IDLE;
      operation_flags <= vrhp_pkg::vrhp_flags_type'(`VRHP_FLAGS_RESET | 4'h1);
      busy_cnt        <= cyc(RESET_CYCLES);
      cmd             <= `VRHP_CMD_NOP;
      nib_left        <= 3'h0;
      nib_idx         <= 3'h0;
      phrase          <= 8'h00;
      vox_on          <= 1'b0;
      level_field     <= `VRHP_LEVEL_RESET;
      ramp_select     <= 2'h0;
      delete_all      <= 1'b0;
      delete_one      <= 1'b0;
      data_out        <= 4'h0;
      data_oe_n       <= 4'hF;
    end else begin
      state           <= next_state;
      operation_flags <= next_flags;
      busy_cnt        <= next_busy_cnt;
      cmd             <= next_cmd;
      nib_left        <= next_nib_left;
      nib_idx         <= next_nib_idx;
      phrase          <= next_phrase;
      vox_on          <= next_vox_on;
      level_field     <= next_level;
      ramp_select     <= next_ramp;
      delete_all      <= next_del_all;
      delete_one      <= next_del_one;
      data_out        <= next_dout;
      data_oe_n       <= next_oe_n;
    end
  end

  // Pins mirror the flag flops directly; the bus nibble is registered from them and lags by one cycle.
  always_comb begin
    busy                 = operation_flags.busy;
    record_play_active   = operation_flags.active;
    voice_wait_or_paused = operation_flags.wait_pause;
    phrase_select_ready  = operation_flags.ready;
  end

  busy_after_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_take |=> busy) else $error("busy not raised after write");
  reset_flags_a: assert property (@(posedge core_clk)
    sys_rst |=> operation_flags == 4'h9) else $error("bad flags after reset");
  read_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lvl.rd && lvl.en) |=> data_oe_n == 4'h0) else $error("bus not driven");
  read_take_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_take |-> data_oe_n == 4'h0) else $error("read strobe not answered");
  float_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !lvl.en |=> data_oe_n == 4'hF) else $error("bus driven while disabled");
  start_active_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_take && state != vrhp_pkg::VRHP_DATA && data_in == `VRHP_CMD_START)
    |=> record_play_active && !phrase_select_ready) else $error("start ignored");
  ramp_store_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_take && state == vrhp_pkg::VRHP_DATA && cmd == `VRHP_CMD_LEV)
    |=> ramp_select == ($past(data_in[1]) ? $past(data_in[1:0]) : 2'h0))
    else $error("ramp not stored");
  delete_all_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    delete_all |-> phrase == 8'h00) else $error("delete all on other phrase");
  voice_go_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == vrhp_pkg::VRHP_VWAIT && voice_detected && !wr_take)
    |=> !voice_wait_or_paused) else $error("voice wait not released");
  busy_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    busy == (busy_cnt != '0)) else $error("busy pin out of step");
endmodule
`default_nettype wire

/* File: dv/vrhp_host_model.sv */
// Host microcontroller model that drives the nibble bus of the port.
`timescale 1ns/100ps
`default_nettype none
module vrhp_host_model (
  // Clock
  input  wire logic       core_clk,
  // Bus to the device
  output var  logic       rd_n,
  output var  logic       wr_n,
  output var  logic       en_n,
  output var  logic       en,
  output var  logic [3:0] data_in,
  input  wire logic [3:0] data_oe_n
);
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    en_n = 1'b0;
    en = 1'b1;
    data_in = 4'h5;
  end

  task automatic set_en(input logic low_en, input logic high_en);
    @(negedge core_clk);
    en_n = low_en;
    en = high_en;
  endtask

  // Lines released after a write show the inverse, so a late sample never matches.
  task automatic write_nib(input logic [3:0] nib);
    @(negedge core_clk);
    data_in = nib;
    wr_n = 1'b0;
    repeat (5) @(negedge core_clk);
    wr_n = 1'b1;
    @(negedge core_clk);
    data_in = ~nib;
  endtask

  task automatic read_stat(output bit ok);
    int n;
    n = 0;
    @(negedge core_clk);
    rd_n = 1'b0;
    while (data_oe_n !== 4'h0 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    ok = (n < 8);
    @(negedge core_clk);
    rd_n = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/vrhp_host_port_tb_top.sv */
// Self-checking testbench of the host command and status port.
`timescale 1ns/100ps
`default_nettype none
module vrhp_host_port_tb_top;
  localparam int RST_C = 20;
  localparam int D1_C  = 30;
  localparam int DA_C  = 50;
  logic       core_clk, sys_rst, rd_n, wr_n, en_n, en;
  logic       voice_detected, op_done, oe_was, saw_all, saw_one;
  logic [3:0] data_in, data_out, data_oe_n;
  logic       busy, record_play_active, voice_wait_or_paused, phrase_select_ready;
  logic [1:0] level_field, ramp_select, lv;
  logic       delete_all, delete_one;
  logic [3:0] expq[$];
  logic [4:0] exp_st;
  logic [3:0] st_pins;
  int         miscompares, samples_checked, run, last_run, cyc;
  int unsigned rnd;
  bit         ok;

  vrhp_host_port #(.RESET_CYCLES(RST_C), .DELALL_CYCLES(DA_C), .PHRASE_DELETE_CYCLES(D1_C))
    vrhp_host_port_i (.core_clk(core_clk), .sys_rst(sys_rst), .rd_n(rd_n), .wr_n(wr_n),
    .en_n(en_n), .en(en), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .busy(busy), .record_play_active(record_play_active),
    .voice_wait_or_paused(voice_wait_or_paused), .phrase_select_ready(phrase_select_ready),
    .voice_detected(voice_detected), .op_done(op_done), .level_field(level_field),
    .ramp_select(ramp_select), .delete_all(delete_all), .delete_one(delete_one));

  vrhp_host_model vrhp_host_model_i (.core_clk(core_clk), .rd_n(rd_n), .wr_n(wr_n),
    .en_n(en_n), .en(en), .data_in(data_in), .data_oe_n(data_oe_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Status reads are noted here and judged by the watcher below.
  task automatic rd(input logic [3:0] e);
    expq.push_back(e);
    vrhp_host_model_i.read_stat(ok);
    chk(ok, 1);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
    end
    repeat (2) @(negedge core_clk);
  endtask

  task automatic cmd(input logic [3:0] nib);
    wait_idle;
    vrhp_host_model_i.write_nib(nib);
    wait_idle;
  endtask

  // The bus nibble and the status pins are both held against the noted value.
  always @(negedge core_clk) begin
    if (data_oe_n === 4'h0 && oe_was) begin
      exp_st = expq.size() != 0 ? {1'b0, expq.pop_front()} : 5'h10;
      st_pins = {phrase_select_ready, voice_wait_or_paused, record_play_active, busy};
      chk({1'b0, data_out}, exp_st);
      chk({1'b0, st_pins}, exp_st);
    end
    oe_was = (data_oe_n !== 4'h0);
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (delete_all === 1'b1) saw_all <= 1'b1;
    if (delete_one === 1'b1) saw_one <= 1'b1;
    if (busy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (cyc == 80000) begin
      miscompares++;
      close_out;
    end
  end

  initial begin
    rnd = $urandom(43);
    sys_rst = 1'b1;
    voice_detected = 1'b0;
    op_done = 1'b0;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(4'h9);
    wait_idle;
    chk(last_run >= RST_C, 1);
    rd(4'h8);
    cmd(4'h0);
    chk(last_run, 400);
    // Disabled enables: neither strobe may be taken.
    for (int k = 0; k < 3; k++) begin
      vrhp_host_model_i.set_en(k != 1, k == 2);
      vrhp_host_model_i.write_nib(4'h4);
      chk(busy, 0);
      vrhp_host_model_i.read_stat(ok);
      chk(ok, 0);
    end
    vrhp_host_model_i.set_en(1'b0, 1'b1);
    cmd(4'h4);
    rd(4'h2);
    cmd(4'h1);
    rd(4'h6);
    cmd(4'h4);
    rd(4'h2);
    @(negedge core_clk);
    op_done = 1'b1;
    @(negedge core_clk);
    op_done = 1'b0;
    rd(4'h8);
    cmd(4'hC);
    cmd(4'h3);
    cmd(4'h4);
    rd(4'h6);
    voice_detected = 1'b1;
    repeat (4) @(negedge core_clk);
    rd(4'h2);
    cmd(4'h5);
    rd(4'h8);
    cmd(4'hC);
    cmd(4'h0);
    for (int r = 0; r < 4; r++) begin
      lv = 2'($urandom);
      cmd(4'hE);
      cmd({lv, 2'(r)});
      chk(last_run, 400);
      chk({level_field, ramp_select}, {lv, ((r >= 2) ? 2'(r) : 2'h0)});
    end
    for (int p = 0; p < 2; p++) begin
      saw_all = 1'b0;
      saw_one = 1'b0;
      cmd(4'h7);
      cmd(p == 0 ? 4'h0 : 4'(1 + rnd % 15));
      cmd(4'h0);
      cmd(4'hD);
      chk(last_run, p == 0 ? DA_C : D1_C);
      chk({saw_all, saw_one}, p == 0 ? 2'h2 : 2'h1);
    end
    cmd(4'hA);
    for (int a = 0; a < 5; a++) begin
      cmd(4'(a + 3));
      chk(last_run, a == 4 ? 6750 : 400);
    end
    cmd(4'h6);
    cmd(4'h1);
    chk(last_run, 400);
    cmd(4'h8);
    cmd(4'h1);
    cmd(4'h2);
    chk(last_run, 400);
    cmd(4'h9);
    chk(last_run, 6750);
    for (int d = 0; d < 2; d++) begin
      cmd(4'h0);
      chk(last_run, 1250);
    end
    cmd(4'hE);
    cmd(4'h7);
    cmd(4'h4);
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    chk({level_field, ramp_select}, 4'h0);
    rd(4'h9);
    wait_idle;
    rd(4'h8);
    close_out;
  end
endmodule
`default_nettype wire
